/* File: rtl/vrm_monitor.sv */
`timescale 1ns/1ns
`include "vrm_cfg.svh"

module vrm_monitor #(
    parameter int NCH = 2,
    parameter int WIN_LEN = `VRM_WIN_LEN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control port access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire vrm_pkg::vrm_addr_t reg_addr,
    input wire vrm_pkg::vrm_byte_t reg_wdata,
    input wire logic [1:0] reg_chan_sel,
    output vrm_pkg::vrm_byte_t reg_rdata,
    // Converter samples, one per clock
    input wire vrm_pkg::vrm_sample_t din_a,
    input wire vrm_pkg::vrm_sample_t din_b,
    // Output samples and status pins
    output vrm_pkg::vrm_sample_t dout_a,
    output vrm_pkg::vrm_sample_t dout_b,
    output logic [1:0] status_overrange_pins
);
    import vrm_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Complex pairing needs exactly the A/B pair
    if (NCH != 2) begin : g_bad_nch
        $error("vrm_monitor supports exactly two channels");
    end
    if (WIN_LEN < 2 || WIN_LEN > 65535) begin : g_bad_win
        $error("vrm_monitor window length out of range");
    end

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Cosine of phase k*2pi/16, scaled by 127
    function automatic logic signed [8:0] cos16(input logic [3:0] k);
        logic [3:0] q;
        logic signed [8:0] v;
        // Mirror the upper half; phase 8 must not fold onto phase 0
        q = k[3] ? 4'(5'h10 - {1'b0, k}) : k;
        v = `VRM_COS_4;
        case (q)
            4'h0: v = `VRM_COS_0;
            4'h1: v = `VRM_COS_1;
            4'h2: v = `VRM_COS_2;
            4'h3: v = `VRM_COS_3;
            4'h4: v = `VRM_COS_4;
            4'h5: v = -`VRM_COS_3;
            4'h6: v = -`VRM_COS_2;
            4'h7: v = -`VRM_COS_1;
            4'h8: v = -`VRM_COS_0;
            default: v = `VRM_COS_4;
        endcase
        return v;
    endfunction : cos16

    // Absolute value with saturation to the magnitude range
    function automatic logic [14:0] absval(input logic signed [15:0] x);
        logic [15:0] a;
        a = x[15] ? 16'(-x) : 16'(x);
        return a[15] ? `VRM_MAG_MAX : a[14:0];
    endfunction : absval

    // Cheap complex magnitude: max + min/2
    function automatic logic [14:0] cmag(input logic [14:0] a,
                                         input logic [14:0] b);
        logic [15:0] s;
        s = (a > b) ? ({1'b0, a} + {2'b0, b[14:1]})
                    : ({1'b0, b} + {2'b0, a[14:1]});
        return s[15] ? `VRM_MAG_MAX : s[14:0];
    endfunction : cmag

    // Resolution from peak level, 6 dB per bit above -30 dBFS
    function automatic vrm_bits_t bits_of(input logic [14:0] lvl);
        vrm_bits_t b;
        b = `VRM_FULL_BITS;
        if (lvl > `VRM_THR_30DB) b = 4'(`VRM_FULL_BITS - 4'h1);
        if (lvl > `VRM_THR_24DB) b = 4'(`VRM_FULL_BITS - 4'h2);
        if (lvl > `VRM_THR_18DB) b = 4'(`VRM_FULL_BITS - 4'h3);
        if (lvl > `VRM_THR_12DB) b = 4'(`VRM_FULL_BITS - 4'h4);
        if (lvl > `VRM_THR_6DB) b = `VRM_MIN_BITS;
        return b;
    endfunction : bits_of

    // Mask keeping the top n bits of a sample
    function automatic logic [13:0] keep_mask(input vrm_bits_t n);
        logic [13:0] m;
        m = 14'h3fff << (`VRM_FULL_BITS - n);
        return m;
    endfunction : keep_mask

    // ------------------------------------------------------------------
    // Per-channel configuration registers
    // ------------------------------------------------------------------
    vrm_byte_t mode_reg [NCH];
    vrm_byte_t tune_reg [NCH];
    vrm_byte_t stat_reg [NCH];
    vrm_bits_t res [NCH];
    logic rd_ch;

    // Writes go to every selected channel, so both can share a setup
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NCH; c++) begin
                mode_reg[c] <= `VRM_MODE_RST;
                tune_reg[c] <= `VRM_TUNE_RST;
                stat_reg[c] <= `VRM_STAT_RST;
            end
        end else if (reg_wr) begin
            for (int c = 0; c < NCH; c++) begin
                if (reg_chan_sel[c]) begin
                    if (reg_addr == `VRM_ADDR_MODE)
                        mode_reg[c] <= reg_wdata;
                    if (reg_addr == `VRM_ADDR_TUNE)
                        tune_reg[c] <= reg_wdata;
                    if (reg_addr == `VRM_ADDR_STAT)
                        stat_reg[c] <= reg_wdata;
                end
            end
        end
    end

    // Read-back from the lowest selected channel, zero when unmapped
    assign rd_ch = !reg_chan_sel[0];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `VRM_UNMAPPED;
        end else if (reg_rd) begin
            case (reg_addr)
                `VRM_ADDR_MODE: reg_rdata <= mode_reg[rd_ch];
                `VRM_ADDR_TUNE: reg_rdata <= tune_reg[rd_ch];
                `VRM_ADDR_STAT: reg_rdata <= stat_reg[rd_ch];
                `VRM_ADDR_RES: reg_rdata <= {4'h0, res[rd_ch]};
                default: reg_rdata <= `VRM_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Shift to baseband around the tuned center
    // ------------------------------------------------------------------
    logic [3:0] phase [NCH];
    logic signed [14:0] yr [NCH];
    logic signed [14:0] yi [NCH];
    logic signed [14:0] next_yr [NCH];
    logic signed [14:0] next_yi [NCH];

    // Phase steps by the tuning word each sample: center = n*fs/16
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NCH; c++) phase[c] <= 4'h0;
        end else begin
            for (int c = 0; c < NCH; c++)
                phase[c] <= phase[c] +
                    tune_reg[c][`VRM_TUNE_MSB:`VRM_TUNE_LSB];
        end
    end

    // Multiply by exp(-j*phase); real input has no quadrature part
    always_comb begin
        logic signed [13:0] xi;
        logic signed [8:0] cs;
        logic signed [8:0] sn;
        logic signed [23:0] pr;
        logic signed [23:0] pi;
        xi = '0;
        cs = '0;
        sn = '0;
        pr = '0;
        pi = '0;
        for (int c = 0; c < NCH; c++) begin
            xi = mode_reg[c][`VRM_MODE_CPLX] ? din_b : 14'sh0;
            cs = cos16(phase[c]);
            sn = cos16(4'(phase[c] - `VRM_SIN_OFS));
            pr = 24'(din_a * cs) + 24'(xi * sn);
            pi = 24'(xi * cs) - 24'(din_a * sn);
            if (c != 0 && !mode_reg[c][`VRM_MODE_CPLX]) begin
                pr = 24'(din_b * cs);
                pi = -24'(din_b * sn);
            end
            next_yr[c] = pr[21:`VRM_MIX_SHIFT];
            next_yi[c] = pi[21:`VRM_MIX_SHIFT];
        end
    end

    // Baseband sample register plus three taps of history
    logic signed [14:0] hr [NCH][3];
    logic signed [14:0] hi [NCH][3];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NCH; c++) begin
                yr[c] <= '0;
                yi[c] <= '0;
                for (int t = 0; t < 3; t++) begin
                    hr[c][t] <= '0;
                    hi[c][t] <= '0;
                end
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                yr[c] <= next_yr[c];
                yi[c] <= next_yi[c];
                hr[c][0] <= yr[c];
                hi[c][0] <= yi[c];
                for (int t = 1; t < 3; t++) begin
                    hr[c][t] <= hr[c][t-1];
                    hi[c][t] <= hi[c][t-1];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Out-of-band residue and its magnitude
    // ------------------------------------------------------------------
    // Residue = sample minus in-band average. Four-tap average nulls
    // beyond fs/8 for the narrow band; two taps widen it for 43 % in complex mode only.
    logic [14:0] mag [NCH];
    always_comb begin
        logic signed [16:0] sr;
        logic signed [16:0] si;
        logic signed [15:0] rr;
        logic signed [15:0] ri;
        sr = '0;
        si = '0;
        rr = '0;
        ri = '0;
        for (int c = 0; c < NCH; c++) begin
            if (mode_reg[c][`VRM_MODE_BW43] &&
                mode_reg[c][`VRM_MODE_CPLX]) begin
                sr = 17'(yr[c] + hr[c][0]) <<< 1;
                si = 17'(yi[c] + hi[c][0]) <<< 1;
            end else begin
                sr = 17'(yr[c]) + 17'(hr[c][0]) +
                     17'(hr[c][1]) + 17'(hr[c][2]);
                si = 17'(yi[c]) + 17'(hi[c][0]) +
                     17'(hi[c][1]) + 17'(hi[c][2]);
            end
            rr = 16'(yr[c]) - 16'(sr >>> 2);
            ri = 16'(yi[c]) - 16'(si >>> 2);
            // Real input: the mirror image is no violation
            if (!mode_reg[c][`VRM_MODE_CPLX]) ri = '0;
            mag[c] = cmag(absval(rr), absval(ri));
        end
    end

    // ------------------------------------------------------------------
    // Peak hold over a window, then resolution decision
    // ------------------------------------------------------------------
    // Decision per window, so a single-sample spike is not missed but
    // the resolution does not chatter sample by sample.
    logic [14:0] peak [NCH];
    logic [15:0] win_cnt;
    logic win_end;
    assign win_end = (win_cnt == 16'(WIN_LEN - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_cnt <= '0;
        end else begin
            win_cnt <= win_end ? 16'h0 : 16'(win_cnt + 16'h1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NCH; c++) begin
                peak[c] <= '0;
                res[c] <= `VRM_FULL_BITS;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!mode_reg[c][`VRM_MODE_EN]) begin
                    peak[c] <= '0;
                    res[c] <= `VRM_FULL_BITS;
                end else if (win_end) begin
                    peak[c] <= '0;
                    res[c] <= bits_of((mag[c] > peak[c]) ?
                                      mag[c] : peak[c]);
                end else if (mag[c] > peak[c]) begin
                    peak[c] <= mag[c];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output samples and status pins
    // ------------------------------------------------------------------
    // Low bits cleared only; the sample keeps its scale
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_a <= '0;
            dout_b <= '0;
        end else begin
            dout_a <= din_a & keep_mask(res[0]);
            dout_b <= din_b & keep_mask(res[1]);
        end
    end

    // One source per pin; select field picks it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_overrange_pins <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                case (vrm_src_t'(stat_reg[c][`VRM_STAT_MSB:
                                             `VRM_STAT_LSB]))
                    VRM_SRC_PUNISH:
                        status_overrange_pins[c] <=
                            (res[c] < 4'(`VRM_FULL_BITS - 4'h1));
                    VRM_SRC_HILO:
                        status_overrange_pins[c] <=
                            (res[c] < `VRM_FULL_BITS);
                    default:
                        status_overrange_pins[c] <= 1'b0;
                endcase
            end
        end
    end

endmodule : vrm_monitor

/* File: rtl/vrm_cfg.svh */
`ifndef VRM_CFG_SVH
`define VRM_CFG_SVH

// ----------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------
`define VRM_ADDR_MODE 12'h430
`define VRM_ADDR_TUNE 12'h434
`define VRM_ADDR_STAT 12'h559
`define VRM_ADDR_RES 12'h431
`define VRM_MODE_EN 0
`define VRM_MODE_CPLX 1
`define VRM_MODE_BW43 2
`define VRM_TUNE_LSB 0
`define VRM_TUNE_MSB 3
`define VRM_MODE_RST 8'h00
`define VRM_TUNE_RST 8'h04
`define VRM_STAT_RST 8'h00
`define VRM_STAT_LSB 0
`define VRM_STAT_MSB 1
`define VRM_UNMAPPED 8'h00

// ----------------------------------------------------------------------
// Resolution steps and mask thresholds, 14-bit magnitude scale
// ----------------------------------------------------------------------
`define VRM_FULL_BITS 4'he
`define VRM_MIN_BITS 4'h9
`define VRM_THR_30DB 15'h0103
`define VRM_THR_24DB 15'h0206
`define VRM_THR_18DB 15'h040b
`define VRM_THR_12DB 15'h0812
`define VRM_THR_6DB 15'h100a
`define VRM_MAG_MAX 15'h7fff

// ----------------------------------------------------------------------
// Mixer table, one quarter wave of cosine in steps of fs/16
// ----------------------------------------------------------------------
`define VRM_COS_0 9'h07f
`define VRM_COS_1 9'h075
`define VRM_COS_2 9'h05a
`define VRM_COS_3 9'h031
`define VRM_COS_4 9'h000
`define VRM_MIX_SHIFT 7
`define VRM_SIN_OFS 4'h4

// Peak detection window, samples
`define VRM_WIN_LEN 64

`endif

/* File: rtl/vrm_pkg.sv */
package vrm_pkg;
    // Status pin source choice
    typedef enum logic [1:0] {
        VRM_SRC_OFF,
        VRM_SRC_PUNISH,
        VRM_SRC_HILO,
        VRM_SRC_RSVD
    } vrm_src_t;

    typedef logic signed [13:0] vrm_sample_t;
    typedef logic [7:0] vrm_byte_t;
    typedef logic [11:0] vrm_addr_t;
    typedef logic [3:0] vrm_bits_t;
endpackage : vrm_pkg

/* File: verification/vrm_monitor_chk.sv */
`timescale 1ns/1ns
module vrm_monitor_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire vrm_pkg::vrm_addr_t reg_addr,
    input wire vrm_pkg::vrm_byte_t reg_wdata,
    input wire logic [1:0] reg_chan_sel,
    input wire vrm_pkg::vrm_byte_t reg_rdata,
    // Samples and status
    input wire vrm_pkg::vrm_sample_t din_a,
    input wire vrm_pkg::vrm_sample_t din_b,
    input wire vrm_pkg::vrm_sample_t dout_a,
    input wire vrm_pkg::vrm_sample_t dout_b,
    input wire logic [1:0] status_overrange_pins
);
    import vrm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Write, one idle cycle, then read of the same channel A register
    property p_readback(logic [11:0] a);
        reg_wr && reg_addr == a && reg_chan_sel == 2'h1 ##2
        reg_rd && reg_addr == a && reg_chan_sel == 2'h1
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_top_bits: assert property (arst_n && $past(arst_n) |->
        (dout_a & 14'h3fe0) == ($past(din_a) & 14'h3fe0))
        else $error("upper nine bits not passed");
    a_only_clears: assert property ($past(arst_n) |->
        ((dout_a & ~$past(din_a)) | (dout_b & ~$past(din_b))) == 14'h0)
        else $error("output bit set that input lacked");
    a_res_floor: assert property (reg_rd && reg_addr == 12'h431 |=>
        reg_rdata >= 8'h09 && reg_rdata <= 8'h0e)
        else $error("resolution outside nine to fourteen");
    a_mode_readback: assert property (p_readback(12'h430))
        else $error("mode register readback wrong");
    a_tune_readback: assert property (p_readback(12'h434))
        else $error("tuning register readback wrong");
    a_select_readback: assert property (p_readback(12'h559))
        else $error("status select readback wrong");
    a_disable_clears: assert property (reg_wr && reg_addr == 12'h430 &&
        reg_chan_sel == 2'h3 && !reg_wdata[0] |->
        ##[1:20] status_overrange_pins == 2'h0)
        else $error("pins stay high after disable");
    a_select_off: assert property (reg_wr && reg_addr == 12'h559 &&
        reg_chan_sel == 2'h3 && reg_wdata[1:0] == 2'h0 |->
        ##[1:6] status_overrange_pins == 2'h0)
        else $error("pins stay high with source off");
    // Settled high indication means the lowest bit is discarded
    a_reduced_lsb: assert property (status_overrange_pins[0] &&
        ($past(status_overrange_pins) & 2'h1) != 2'h0 |->
        dout_a[0] == 1'b0)
        else $error("indication high with full resolution");
    c_enable: cover property (reg_wr && reg_addr == 12'h430 && reg_wdata[0]);
    c_complex: cover property (reg_wr && reg_addr == 12'h430 && reg_wdata[1]);
    c_pin_high: cover property (status_overrange_pins[0]);
    c_res_read: cover property (reg_rd && reg_addr == 12'h431);
endmodule : vrm_monitor_chk

bind vrm_monitor vrm_monitor_chk u_chk (.clk(clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_chan_sel(reg_chan_sel),
    .reg_rdata(reg_rdata), .din_a(din_a), .din_b(din_b),
    .dout_a(dout_a), .dout_b(dout_b),
    .status_overrange_pins(status_overrange_pins));

/* File: verification/vrm_sink.sv */
`timescale 1ns/1ns
module vrm_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Indication routed to the pin
    input wire vrm_pkg::vrm_src_t src,
    input wire logic pin,
    // Sample stream
    input wire vrm_pkg::vrm_sample_t sample,
    output vrm_pkg::vrm_bits_t max_bits,
    output vrm_pkg::vrm_sample_t held
);
    import vrm_pkg::*;
    // Latch samples and decode the most bits the pin still allows;
    // a low punish bit cannot tell 14 from 13, so it claims 14
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held <= '0;
            max_bits <= 4'he;
        end else begin
            held <= sample;
            case (src)
                VRM_SRC_PUNISH: max_bits <= pin ? 4'hc : 4'he;
                VRM_SRC_HILO: max_bits <= pin ? 4'hd : 4'he;
                default: max_bits <= 4'he;
            endcase
        end
    end
endmodule : vrm_sink

/* File: verification/test_variable_dynamic_range_monitor.sv */
`timescale 1ns/1ns
module test_variable_dynamic_range_monitor;
    import vrm_pkg::*;
    // Register case: write, then read back on a channel
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic [1:0] wsel;
        logic [1:0] rsel;
        logic [7:0] exp;
    } vrm_row_t;
    logic clk;
    logic arst_n;
    logic reg_wr;
    logic reg_rd;
    vrm_addr_t reg_addr;
    vrm_byte_t reg_wdata;
    logic [1:0] reg_chan_sel;
    vrm_byte_t reg_rdata;
    vrm_sample_t din_a;
    vrm_sample_t din_b;
    vrm_sample_t dout_a;
    vrm_sample_t dout_b;
    vrm_sample_t prev_a;
    logic [1:0] status_overrange_pins;
    vrm_src_t sink_src;
    vrm_bits_t max_bits;
    logic [1:0] tone;
    logic [1:0] tph;
    vrm_sample_t sink_held;
    int fail_count;
    int tests_run;
    vrm_byte_t rv;
    vrm_row_t rows [8];

    vrm_monitor #(.WIN_LEN(8)) dut (.clk(clk), .arst_n(arst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_chan_sel(reg_chan_sel),
        .reg_rdata(reg_rdata), .din_a(din_a), .din_b(din_b),
        .dout_a(dout_a), .dout_b(dout_b),
        .status_overrange_pins(status_overrange_pins));
    vrm_sink u_sink (.clk(clk), .arst_n(arst_n), .src(sink_src),
        .pin(status_overrange_pins[0]), .sample(dout_a),
        .max_bits(max_bits), .held(sink_held));

    // ----------------------------------------------------------------
    // Clock, tone source, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Tone: 1 is fs/2 on A; 2 and 3 are complex plus and minus fs/4
    always @(posedge clk) begin
        if (tone == 2'h1) begin
            prev_a <= din_a;
            din_a <= #1 ~din_a;
        end else if (tone != 2'h0) begin
            tph <= tph + 2'h1;
            din_a <= #1 tph[0] ? 14'h0000 :
                (tph[1] ? 14'h2001 : 14'h1fff);
            din_b <= #1 !tph[0] ? 14'h0000 :
                ((tph[1] ^ tone[0]) ? 14'h2001 : 14'h1fff);
        end
    end
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Write leaves one idle cycle so strobes never bounce in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] s);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        reg_chan_sel = s;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [1:0] s,
                      output logic [7:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        reg_chan_sel = s;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic finish_test;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_chan_sel = 2'h0;
        din_a = 14'h0000;
        din_b = 14'h0000;
        prev_a = 14'h0000;
        tone = 2'h0;
        tph = 2'h0;
        sink_src = VRM_SRC_OFF;
        fail_count = 0;
        tests_run = 0;
        rows[0] = '{12'h434, 8'h05, 2'h1, 2'h1, 8'h05};
        rows[1] = '{12'h434, 8'h0f, 2'h2, 2'h2, 8'h0f};
        rows[2] = '{12'h430, 8'h07, 2'h1, 2'h1, 8'h07};
        rows[3] = '{12'h430, 8'h03, 2'h2, 2'h2, 8'h03};
        rows[4] = '{12'h430, 8'h00, 2'h1, 2'h2, 8'h03};
        rows[5] = '{12'h559, 8'h02, 2'h1, 2'h1, 8'h02};
        rows[6] = '{12'h431, 8'h0b, 2'h1, 2'h1, 8'h0e};
        rows[7] = '{12'h500, 8'h5a, 2'h3, 2'h1, 8'h00};
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata, rows[i].wsel);
            rd(rows[i].addr, rows[i].rsel, rv);
            check({8'h00, rv}, {8'h00, rows[i].exp});
        end
        // Second reset restores the reset values, not those written
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        rd(12'h430, 2'h1, rv);
        check({8'h00, rv}, 16'h0000);
        rd(12'h434, 2'h2, rv);
        check({8'h00, rv}, 16'h0004);
        rd(12'h431, 2'h1, rv);
        check({8'h00, rv}, 16'h000e);
        // Disabled channels pass every bit
        din_a = 14'h1abc;
        din_b = 14'h2345;
        @(posedge clk);
        #1;
        check({2'b00, dout_a}, {2'b00, 14'h1abc});
        check({2'b00, dout_b}, {2'b00, 14'h2345});
        // Real mode, center word 4, loud tone on A, silence on B
        din_a = 14'h1fff;
        din_b = 14'h0000;
        wr(12'h434, 8'h04, 2'h3);
        wr(12'h559, 8'h02, 2'h3);
        wr(12'h430, 8'h01, 2'h3);
        sink_src = VRM_SRC_HILO;
        tone = 2'h1;
        repeat (40) @(posedge clk);
        #1;
        check({2'b00, dout_a}, {2'b00, prev_a & 14'h3fe0});
        check({14'h0, status_overrange_pins}, 16'h0001);
        check({12'h0, max_bits}, 16'h000d);
        rd(12'h431, 2'h1, rv);
        check({8'h00, rv}, 16'h0009);
        rd(12'h431, 2'h2, rv);
        check({8'h00, rv}, 16'h000e);
        wr(12'h559, 8'h01, 2'h1);
        sink_src = VRM_SRC_PUNISH;
        repeat (3) @(posedge clk);
        #1;
        check({14'h0, status_overrange_pins}, 16'h0001);
        check({12'h0, max_bits}, 16'h000c);
        wr(12'h559, 8'h00, 2'h3);
        repeat (3) @(posedge clk);
        #1;
        check({14'h0, status_overrange_pins}, 16'h0000);
        wr(12'h430, 8'h00, 2'h3);
        tone = 2'h0;
        rd(12'h431, 2'h1, rv);
        check({8'h00, rv}, 16'h000e);
        check({2'b00, dout_a}, {2'b00, din_a});
        check({2'b00, sink_held}, {2'b00, din_a});
        // Complex 43 %, I on A and Q on B, tone at the tuned center
        wr(12'h430, 8'h07, 2'h3);
        tone = 2'h2;
        repeat (40) @(posedge clk);
        #1;
        rd(12'h431, 2'h1, rv);
        check({8'h00, rv}, 16'h000e);
        // Mirror image at minus fs/4 lies in the mask zone
        tone = 2'h3;
        repeat (40) @(posedge clk);
        #1;
        rd(12'h431, 2'h2, rv);
        check({8'h00, rv}, 16'h0009);
        // Narrow complex band sees the same violation
        wr(12'h430, 8'h03, 2'h3);
        repeat (40) @(posedge clk);
        #1;
        rd(12'h431, 2'h1, rv);
        check({8'h00, rv}, 16'h0009);
        finish_test();
    end
endmodule : test_variable_dynamic_range_monitor
